// >>> core/dhbi_pkg.sv
// Shared constants and types for the display host bus interface
package dhbi_pkg;
  // ==========================================================
  // Interface selection straps, {select_high, select_low}
  localparam logic [1:0] SEL_6800 = 2'h2;
  localparam logic [1:0] SEL_8080 = 2'h3;
  localparam logic [1:0] SEL_SERIAL = 2'h0;

  // ==========================================================
  // Timing, given in ns and converted to host clock cycles
  localparam int HOST_CLK_MHZ = 100;
  localparam int LINK_HALF_NS = 20;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * HOST_CLK_MHZ + 999) / 1000;
  localparam int PHASE_NS = 320;
  localparam int PHASE_CYC = (PHASE_NS * HOST_CLK_MHZ + 999) / 1000;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * HOST_CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Idle and reset levels
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] BITS_PER_BYTE = 3'h7;
  localparam int SYNC_W = 15;

  typedef enum logic [1:0] {
    MODE_6800,
    MODE_8080,
    MODE_SERIAL
  } dhbi_mode_t;

  function automatic dhbi_mode_t dhbi_decode(input logic [1:0] sel);
    dhbi_mode_t m;
    m = MODE_SERIAL;
    if (sel == SEL_6800)
    begin
      m = MODE_6800;
    end
    else if (sel == SEL_8080)
    begin
      m = MODE_8080;
    end
    return m;
  endfunction
endpackage

// >>> core/dhbi_link_if.sv
// Pin-level link between the host end and the display end
`timescale 1ns/1ps
interface dhbi_link_if;
  import dhbi_pkg::*;
  logic link_clk;
  logic chip_sel_n;
  logic strobe_a;
  logic strobe_b;
  logic data_cmd;
  logic interface_select_low;
  logic interface_select_high;
  logic module_reset_n;
  logic [7:0] host_dout;
  logic host_doe;
  logic [7:0] dev_dout;
  logic dev_doe;
  logic [7:0] host_data_bus;

  // ==========================================================
  // Wire resolution, idle bus pulled high
  always_comb
  begin
    if (dev_doe)
    begin
      host_data_bus = dev_dout;
    end
    else if (host_doe)
    begin
      host_data_bus = host_dout;
    end
    else
    begin
      host_data_bus = BUS_IDLE;
    end
  end

  modport host (output link_clk, chip_sel_n, strobe_a, strobe_b, data_cmd, interface_select_low,
    interface_select_high, module_reset_n, host_dout, host_doe, input host_data_bus);
  modport device (input link_clk, chip_sel_n, strobe_a, strobe_b, data_cmd, interface_select_low,
    interface_select_high, module_reset_n, host_data_bus, output dev_dout, dev_doe);
endinterface

// >>> core/dhbi_device_end.sv
// Display end of the host bus: pin decode, serial shifter, receive buffer
// Contract
// R1: Eight-line bidirectional data bus, both parallel modes.
// R2: Serial: data on bit 1, clock bit 0.
// R3: 6800: enable high, select low starts access.
// R4: 6800: host holds direction high read, low write.
// R5: 8080: read strobe low, select low reads.
// R6: 8080: write strobe low, select low writes.
// R7: Data/command high is data, low is command.
// R8: Two static select pins choose interface type.
// R9: Reset low returns defaults, ignores bus.
// R10: Select high ignores strobes, bus released.
`timescale 1ns/1ps
module dhbi_device_end
  import dhbi_pkg::*;
(
  dhbi_link_if.device link,
  input wire logic RX_READY_I,
  input wire logic [7:0] RD_DATA_I,
  output logic RX_VALID_O,
  output logic [7:0] RX_DATA_O,
  output logic RX_IS_DATA_O,
  output logic RX_DROP_O,
  output logic RD_TAKEN_O,
  output logic [1:0] MODE_O,
  output logic IN_RESET_O
);
  // ==========================================================
  // Pin synchronisers, all on the link clock
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  assign pins_raw = {link.module_reset_n, link.interface_select_high, link.interface_select_low,
    link.chip_sel_n, link.strobe_a, link.strobe_b, link.data_cmd, link.host_data_bus};

  always_ff @(posedge link.link_clk)
  begin
    sync1_reg <= pins_raw;
    sync2_reg <= sync1_reg;
  end

  logic s_rst_n;
  logic [1:0] s_sel;
  logic s_cs_n;
  logic s_a;
  logic s_b;
  logic s_dc;
  logic [7:0] s_bus;
  logic rst;

  assign s_rst_n = sync2_reg[14];
  assign s_sel = sync2_reg[13:12];
  assign s_cs_n = sync2_reg[11];
  assign s_a = sync2_reg[10];
  assign s_b = sync2_reg[9];
  assign s_dc = sync2_reg[8];
  assign s_bus = sync2_reg[7:0];
  assign rst = ~s_rst_n;

  // ==========================================================
  // Decode state
  dhbi_mode_t mode_reg, mode_next;
  logic [2:0] prev_reg, prev_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic doe_reg, doe_next;
  logic [7:0] dout_reg, dout_next;
  logic taken_reg, taken_next;
  logic in_rst_reg, in_rst_next;

  logic selected;
  logic wr_evt;
  logic rd_active;
  logic rd_end;
  logic [7:0] wr_byte;
  logic wr_dc;

  always_comb
  begin
    mode_next = mode_reg;
    prev_next = {s_a, s_b, s_bus[0]};
    shift_next = shift_reg;
    bit_next = bit_reg;
    selected = ~s_cs_n; // R10
    wr_evt = 1'b0;
    rd_active = 1'b0;
    rd_end = 1'b0;
    wr_byte = s_bus; // R1
    wr_dc = s_dc; // R7
    if (rst)
    begin
      mode_next = dhbi_decode(s_sel); // R8
    end
    case (mode_reg)
      MODE_6800:
      begin
        rd_active = selected & s_a & s_b; // R3 R4
        rd_end = selected & prev_reg[2] & ~s_a & s_b;
        wr_evt = selected & prev_reg[2] & ~s_a & ~s_b; // R3 R4
      end
      MODE_8080:
      begin
        rd_active = selected & ~s_a; // R5
        rd_end = selected & ~prev_reg[2] & s_a;
        wr_evt = selected & ~prev_reg[1] & s_b; // R6
      end
      MODE_SERIAL:
      begin
        if (!selected)
        begin
          bit_next = 3'h0; // R10
        end
        else if (~prev_reg[0] & s_bus[0])
        begin
          shift_next = {shift_reg[6:0], s_bus[1]}; // R2
          bit_next = bit_reg + 3'h1;
          if (bit_reg == BITS_PER_BYTE)
          begin
            wr_evt = 1'b1;
            wr_byte = {shift_reg[6:0], s_bus[1]};
          end
        end
      end
      default:
      begin
        bit_next = 3'h0;
      end
    endcase
    if (rst)
    begin
      wr_evt = 1'b0; // R9
      rd_active = 1'b0;
      rd_end = 1'b0;
      bit_next = 3'h0;
    end
    doe_next = rd_active; // R1 R10
    dout_next = doe_reg ? dout_reg : RD_DATA_I;
    taken_next = rd_end;
    in_rst_next = rst;
  end

  always_ff @(posedge link.link_clk)
  begin
    if (rst)
    begin
      mode_reg <= mode_next; // R9
      // Track idle pin levels so no false edge follows reset
      prev_reg <= prev_next;
      shift_reg <= BYTE_RESET;
      bit_reg <= 3'h0;
      doe_reg <= 1'b0;
      dout_reg <= BYTE_RESET;
      taken_reg <= 1'b0;
      in_rst_reg <= 1'b1;
    end
    else
    begin
      mode_reg <= mode_next;
      prev_reg <= prev_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      doe_reg <= doe_next;
      dout_reg <= dout_next;
      taken_reg <= taken_next;
      in_rst_reg <= in_rst_next;
    end
  end

  assign link.dev_doe = doe_reg;
  assign link.dev_dout = dout_reg;

  // ==========================================================
  // Two-entry receive buffer: output stage plus skid stage
  logic out_v_reg, out_v_next;
  logic [8:0] out_reg, out_next;
  logic sk_v_reg, sk_v_next;
  logic [8:0] sk_reg, sk_next;
  logic drop_reg, drop_next;
  logic push;
  logic pop;

  always_comb
  begin
    // Skid full means both entries busy: the byte cannot be held
    push = wr_evt & ~sk_v_reg;
    pop = out_v_reg & RX_READY_I;
    out_v_next = out_v_reg;
    out_next = out_reg;
    sk_v_next = sk_v_reg;
    sk_next = sk_reg;
    drop_next = wr_evt & sk_v_reg;
    if (pop)
    begin
      if (sk_v_reg)
      begin
        out_next = sk_reg;
        sk_v_next = 1'b0;
      end
      else
      begin
        out_v_next = push;
        out_next = {wr_dc, wr_byte}; // R7
      end
    end
    else if (!out_v_reg)
    begin
      out_v_next = push;
      out_next = {wr_dc, wr_byte}; // R7
    end
    else if (push)
    begin
      sk_v_next = 1'b1;
      sk_next = {wr_dc, wr_byte};
    end
  end

  always_ff @(posedge link.link_clk)
  begin
    if (rst)
    begin
      out_v_reg <= 1'b0; // R9
      out_reg <= 9'h000;
      sk_v_reg <= 1'b0;
      sk_reg <= 9'h000;
      drop_reg <= 1'b0;
    end
    else
    begin
      out_v_reg <= out_v_next;
      out_reg <= out_next;
      sk_v_reg <= sk_v_next;
      sk_reg <= sk_next;
      drop_reg <= drop_next;
    end
  end

  // ==========================================================
  // User side
  assign RX_VALID_O = out_v_reg;
  assign RX_DATA_O = out_reg[7:0];
  assign RX_IS_DATA_O = out_reg[8];
  assign RX_DROP_O = drop_reg;
  assign RD_TAKEN_O = taken_reg;
  assign MODE_O = mode_reg;
  assign IN_RESET_O = in_rst_reg;
endmodule

// >>> core/dhbi_host_end.sv
// Host end: drives the display bus in the strapped mode, makes the link clock
`timescale 1ns/1ps
module dhbi_host_end
  import dhbi_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [1:0] MODE_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_READ_I,
  input wire logic CMD_IS_DATA_I,
  input wire logic [7:0] CMD_DATA_I,
  output logic CMD_READY_O,
  output logic RD_VALID_O,
  output logic [7:0] RD_DATA_O,
  dhbi_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_SLOW, H_SHIGH} dhbi_hstate_t;

  // ==========================================================
  // Link clock divider and bus sampling
  logic [7:0] div_reg, div_next;
  logic lclk_reg, lclk_next;
  logic [7:0] bus_s1_reg;
  logic [7:0] bus_s2_reg;

  always_comb
  begin
    div_next = div_reg + 8'h01;
    lclk_next = lclk_reg;
    if (div_reg == 8'(LINK_HALF_CYC - 1))
    begin
      div_next = 8'h00;
      lclk_next = ~lclk_reg;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    bus_s1_reg <= link.host_data_bus;
    bus_s2_reg <= bus_s1_reg;
    if (RESET_I)
    begin
      div_reg <= 8'h00;
      lclk_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      lclk_reg <= lclk_next;
    end
  end

  // ==========================================================
  // Transfer sequencer
  dhbi_hstate_t st_reg, st_next;
  logic [1:0] sel_reg, sel_next;
  logic [7:0] rcnt_reg, rcnt_next;
  logic [7:0] ph_reg, ph_next;
  logic [2:0] bit_reg, bit_next;
  logic rd_reg, rd_next;
  logic [7:0] dat_reg, dat_next;
  logic cs_n_reg, cs_n_next;
  logic a_reg, a_next;
  logic b_reg, b_next;
  logic dc_reg, dc_next;
  logic [7:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic rst_n_reg, rst_n_next;
  logic rdy_reg, rdy_next;
  logic rv_reg, rv_next;
  logic [7:0] rdat_reg, rdat_next;
  logic ph_done;
  dhbi_mode_t mode;

  always_comb
  begin
    mode = dhbi_decode(sel_reg); // R8
    st_next = st_reg;
    sel_next = sel_reg;
    rcnt_next = rcnt_reg;
    ph_done = (ph_reg == 8'h00);
    ph_next = ph_done ? 8'h00 : ph_reg - 8'h01;
    bit_next = bit_reg;
    rd_next = rd_reg;
    dat_next = dat_reg;
    cs_n_next = cs_n_reg;
    a_next = a_reg;
    b_next = b_reg;
    dc_next = dc_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    rst_n_next = (rcnt_reg == 8'h00);
    rcnt_next = rst_n_next ? 8'h00 : rcnt_reg - 8'h01;
    rv_next = 1'b0;
    rdat_next = rdat_reg;
    case (st_reg)
      H_IDLE:
      begin
        if (CMD_VALID_I && rdy_reg)
        begin
          rd_next = CMD_READ_I;
          dat_next = CMD_DATA_I;
          dc_next = CMD_IS_DATA_I; // R7
          cs_n_next = 1'b0;
          ph_next = 8'(PHASE_CYC - 1);
          if (mode == MODE_SERIAL)
          begin
            // Serial path is write only; a read completes with zero
            if (CMD_READ_I)
            begin
              cs_n_next = 1'b1;
              rv_next = 1'b1;
              rdat_next = BYTE_RESET;
            end
            else
            begin
              st_next = H_SLOW;
              bit_next = 3'h0;
              doe_next = 1'b1;
              dout_next = {6'h3F, CMD_DATA_I[7], 1'b0}; // R2
            end
          end
          else
          begin
            st_next = H_SETUP;
            b_next = (mode == MODE_6800) ? CMD_READ_I : 1'b1; // R4
            doe_next = ~CMD_READ_I; // R1
            dout_next = CMD_DATA_I;
          end
        end
      end
      H_SETUP:
      begin
        if (ph_done)
        begin
          st_next = H_STROBE;
          ph_next = 8'(PHASE_CYC - 1);
          if (mode == MODE_6800)
          begin
            a_next = 1'b1; // R3
          end
          else if (rd_reg)
          begin
            a_next = 1'b0; // R5
          end
          else
          begin
            b_next = 1'b0; // R6
          end
        end
      end
      H_STROBE:
      begin
        if (ph_done)
        begin
          st_next = H_HOLD;
          ph_next = 8'(PHASE_CYC - 1);
          a_next = (mode == MODE_8080);
          b_next = (mode == MODE_6800) ? rd_reg : 1'b1; // R4
          if (rd_reg)
          begin
            rv_next = 1'b1;
            rdat_next = bus_s2_reg;
          end
        end
      end
      H_HOLD:
      begin
        if (ph_done)
        begin
          st_next = H_IDLE;
          cs_n_next = 1'b1;
          doe_next = 1'b0;
          b_next = 1'b1;
        end
      end
      H_SLOW:
      begin
        if (ph_done)
        begin
          st_next = H_SHIGH;
          ph_next = 8'(PHASE_CYC - 1);
          dout_next[0] = 1'b1; // R2
        end
      end
      H_SHIGH:
      begin
        if (ph_done)
        begin
          ph_next = 8'(PHASE_CYC - 1);
          if (bit_reg == BITS_PER_BYTE)
          begin
            st_next = H_HOLD;
          end
          else
          begin
            st_next = H_SLOW;
            bit_next = bit_reg + 3'h1;
            dat_next = {dat_reg[6:0], 1'b0};
            dout_next = {6'h3F, dat_reg[6], 1'b0}; // R2
          end
        end
      end
      default:
      begin
        st_next = H_IDLE;
      end
    endcase
    if (st_reg == H_IDLE && st_next == H_IDLE)
    begin
      a_next = (mode != MODE_6800); // R3 R5
    end
    rdy_next = (st_next == H_IDLE) && rst_n_next && !(CMD_VALID_I && rdy_reg);
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      st_reg <= H_IDLE;
      sel_reg <= MODE_I;
      rcnt_reg <= 8'(RESET_HOLD_CYC);
      ph_reg <= 8'h00;
      bit_reg <= 3'h0;
      rd_reg <= 1'b0;
      dat_reg <= BYTE_RESET;
      cs_n_reg <= 1'b1;
      a_reg <= 1'b1;
      b_reg <= 1'b1;
      dc_reg <= 1'b0;
      dout_reg <= BUS_IDLE;
      doe_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      rdat_reg <= BYTE_RESET;
    end
    else
    begin
      st_reg <= st_next;
      sel_reg <= sel_next;
      rcnt_reg <= rcnt_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      rd_reg <= rd_next;
      dat_reg <= dat_next;
      cs_n_reg <= cs_n_next;
      a_reg <= a_next;
      b_reg <= b_next;
      dc_reg <= dc_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      rst_n_reg <= rst_n_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      rdat_reg <= rdat_next;
    end
  end

  assign link.link_clk = lclk_reg;
  assign link.chip_sel_n = cs_n_reg;
  assign link.strobe_a = a_reg;
  assign link.strobe_b = b_reg;
  assign link.data_cmd = dc_reg;
  assign link.interface_select_low = sel_reg[0];
  assign link.interface_select_high = sel_reg[1];
  assign link.module_reset_n = rst_n_reg;
  assign link.host_dout = dout_reg;
  assign link.host_doe = doe_reg;
  assign CMD_READY_O = rdy_reg;
  assign RD_VALID_O = rv_reg;
  assign RD_DATA_O = rdat_reg;
endmodule

// >>> tb/dhbi_sva.sv
// Concurrent checks on the link between the host end and the display end
`timescale 1ns/1ps
module dhbi_sva
  import dhbi_pkg::*;
(
  input wire logic link_clk,
  input wire logic chip_sel_n,
  input wire logic strobe_a,
  input wire logic strobe_b,
  input wire logic data_cmd,
  input wire logic interface_select_low,
  input wire logic interface_select_high,
  input wire logic module_reset_n,
  input wire logic [7:0] host_dout,
  input wire logic host_doe,
  input wire logic [7:0] dev_dout,
  input wire logic dev_doe,
  input wire logic [7:0] host_data_bus
);
  // ==========================================================
  // Common clock and reset
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!module_reset_n);

  logic [1:0] sel;
  assign sel = {interface_select_high, interface_select_low};

  // ==========================================================
  // Transfer steps
  sequence s_rd_8080;
    (sel == SEL_8080 && !chip_sel_n && !strobe_a) [*5];
  endsequence
  sequence s_rd_6800;
    (sel == SEL_6800 && !chip_sel_n && strobe_a && strobe_b) [*5];
  endsequence
  sequence s_wr_8080;
    sel == SEL_8080 && !chip_sel_n && !strobe_b;
  endsequence
  sequence s_ser_frame;
    (sel[1] == 1'b0 && !chip_sel_n) [*2];
  endsequence

  // ==========================================================
  // Properties
  a_no_contention: assert property (!(dev_doe && host_doe))
    else $error("both ends drive the bus");
  a_read_8080: assert property (s_rd_8080 |-> dev_doe && host_data_bus == dev_dout)
    else $error("8080 read not answered on the bus");
  a_read_6800: assert property (s_rd_6800 |-> dev_doe)
    else $error("6800 read not answered on the bus");
  a_write_8080: assert property (s_wr_8080 |-> host_doe && !dev_doe)
    else $error("8080 write without host drive");
  a_serial_drive: assert property (s_ser_frame |-> host_doe && !dev_doe)
    else $error("serial frame without host drive");
  a_dc_steady: assert property (s_wr_8080 ##1 s_wr_8080 |-> $stable(data_cmd))
    else $error("data/command moved during write strobe");
  a_straps_static: assert property ($stable(sel))
    else $error("interface straps changed out of reset");
  a_idle_release: assert property (chip_sel_n && $past(chip_sel_n, 4) |-> !dev_doe)
    else $error("device drives bus while deselected");
  // Checked through reset itself, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0) !module_reset_n && !$past(module_reset_n, 5) |-> !dev_doe)
    else $error("device drives bus in reset");
endmodule

// >>> tb/display_host_bus_interface_tb.sv
// Self-checking bench joining the host end and the display end
`timescale 1ns/1ps
module display_host_bus_interface_tb
  import dhbi_pkg::*;
;
  localparam logic [1:0] SEL_TAB [4] = '{SEL_6800, SEL_8080, SEL_SERIAL, 2'h1};
  localparam dhbi_mode_t MODE_TAB [4] = '{MODE_6800, MODE_8080, MODE_SERIAL, MODE_SERIAL};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] mode = SEL_6800;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_is_data = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic rx_ready = 1'b0;
  logic [7:0] dev_rd_data = 8'h00;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_is_data;
  logic rx_drop;
  logic [1:0] dev_mode;
  logic in_reset;
  logic [7:0] wire_byte = 8'h00;
  int errors = 0;
  int checks = 0;
  int drops = 0;
  int takes = 0;
  logic rd_taken;

  dhbi_link_if link ();
  dhbi_host_end i_dhbi_host_end (.CLK_I(clk), .RESET_I(reset), .MODE_I(mode), .CMD_VALID_I(cmd_valid),
    .CMD_READ_I(cmd_read), .CMD_IS_DATA_I(cmd_is_data), .CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_ready),
    .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .link(link));
  dhbi_device_end i_dhbi_device_end (.link(link), .RX_READY_I(rx_ready), .RD_DATA_I(dev_rd_data),
    .RX_VALID_O(rx_valid), .RX_DATA_O(rx_data), .RX_IS_DATA_O(rx_is_data), .RX_DROP_O(rx_drop),
    .RD_TAKEN_O(rd_taken), .MODE_O(dev_mode), .IN_RESET_O(in_reset));
  dhbi_sva i_dhbi_sva (.link_clk(link.link_clk), .chip_sel_n(link.chip_sel_n), .strobe_a(link.strobe_a),
    .strobe_b(link.strobe_b), .data_cmd(link.data_cmd), .interface_select_low(link.interface_select_low),
    .interface_select_high(link.interface_select_high), .module_reset_n(link.module_reset_n),
    .host_dout(link.host_dout), .host_doe(link.host_doe), .dev_dout(link.dev_dout), .dev_doe(link.dev_doe),
    .host_data_bus(link.host_data_bus));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Wire watchers: byte as it appears on the bus
  always @(posedge link.host_data_bus[0])
    if (!link.chip_sel_n && !mode[1]) wire_byte <= {wire_byte[6:0], link.host_data_bus[1]};
  always @(posedge link.strobe_b)
    if (!link.chip_sel_n && mode == SEL_8080) wire_byte <= link.host_data_bus;
  always @(negedge link.strobe_a)
    if (!link.chip_sel_n && mode == SEL_6800 && !link.strobe_b) wire_byte <= link.host_data_bus;
  always @(posedge link.link_clk)
    if (rx_drop === 1'b1) drops++;
  always @(posedge link.link_clk)
    if (rd_taken === 1'b1) takes++;

  // ==========================================================
  // Tasks
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timed_out();
    errors++;
    $display("MISMATCH at %0t: wait ran out", $time);
    test_done();
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000) timed_out();
    end
  endtask

  task automatic send(input logic rd, input logic is_data, input logic [7:0] data);
    wait_ready();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_is_data <= is_data;
    cmd_data <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  // Expected value is {is_data, byte}
  task automatic pop(input logic [8:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1)
    begin
      @(posedge link.link_clk);
      #1;
      n++;
      if (n > 300) timed_out();
    end
    check({rx_is_data, rx_data}, exp);
    @(posedge link.link_clk);
    rx_ready <= 1'b1;
    @(posedge link.link_clk);
    rx_ready <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Main sequence: each strap setting, including the spare code
  initial
  begin
    int n;
    int base;
    int tbase;
    logic [7:0] d;
    for (int k = 0; k < 4; k++)
    begin
      d = 8'(k);
      @(posedge clk);
      reset <= 1'b1;
      mode <= SEL_TAB[k];
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      #1;
      wait_ready();
      // Device leaves reset a few link edges after the host end does
      repeat (4) @(posedge link.link_clk);
      #1;
      check({7'h00, dev_mode}, {7'h00, MODE_TAB[k]});
      check({8'h00, in_reset}, 9'h000);
      base = drops;
      // Receiver stalls, so the third byte finds both entries full
      send(1'b0, 1'b1, 8'hA5 + d);
      send(1'b0, 1'b0, 8'h3C + d);
      send(1'b0, 1'b1, 8'hC3 + d);
      n = 0;
      while (drops == base)
      begin
        @(posedge clk);
        n++;
        if (n > 1000) timed_out();
      end
      check({1'b0, wire_byte}, {1'b0, 8'hC3 + d});
      check(9'(drops - base), 9'h001);
      pop({1'b1, 8'hA5 + d});
      pop({1'b0, 8'h3C + d});
      check({8'h00, rx_valid}, 9'h000);
      @(posedge link.link_clk);
      dev_rd_data <= 8'h96 - d;
      tbase = takes;
      send(1'b1, 1'b1, 8'h00);
      n = 0;
      while (rd_valid !== 1'b1)
      begin
        @(posedge clk);
        #1;
        n++;
        if (n > 300) timed_out();
      end
      // Serial straps give a write-only port that returns zero
      check({1'b0, rd_data}, {1'b0, (k < 2) ? 8'h96 - d : 8'h00});
      // Let the read finish at the device before the next reset cuts it
      repeat (8) @(posedge link.link_clk);
      #1;
      check(9'(takes - tbase), (k < 2) ? 9'h001 : 9'h000);
      check({8'h00, rx_valid}, 9'h000);
    end
    test_done();
  end
endmodule
